// File: hw/phase_rail_config_regs.sv
// Input current gain and rail phase sharing configuration registers.
module phase_rail_config_regs (
  // Clock and reset
  input  wire logic                                     sys_clk,
  input  wire logic                                     rst_n,
  // Pin strapped bus address
  input  wire logic [phase_rail_pkg::STRAP_W-1:0]       strapAddr,
  // Command port from the transaction layer
  input  wire logic                                     cmdValid,
  input  wire logic                                     cmdWrite,
  input  wire logic [7:0]                               cmdCode,
  input  wire logic                                     cmdPage,
  input  wire logic [15:0]                              cmdWdata,
  input  wire logic                                     writeProtect,
  output logic                                          cmdAck,
  output logic                                          cmdNack,
  output logic      [15:0]                              cmdRdata,
  // Per output phase_command_a offset from the phase_command_a register
  input  wire logic [phase_rail_pkg::NUM_OUTPUTS-1:0][7:0] phaseCommandA,
  // Gain towards the input current calculation
  output logic signed [4:0]                             gainExponent,
  output logic signed [10:0]                            gainMantissa,
  // Per output configuration
  output logic [phase_rail_pkg::NUM_OUTPUTS-1:0][2:0]   phasePosition,
  output logic [phase_rail_pkg::NUM_OUTPUTS-1:0][4:0]   railIdentifier,
  output logic [phase_rail_pkg::NUM_OUTPUTS-1:0][2:0]   phasesInRail,
  output logic [phase_rail_pkg::NUM_OUTPUTS-1:0]        sharingActive,
  output logic [phase_rail_pkg::NUM_OUTPUTS-1:0][7:0]   phaseOffset
);
  import phase_rail_pkg::*;

  logic                         rstMeta;
  logic                         rstLocal_n;
  logic [STRAP_W-1:0]           strapMeta;
  logic [STRAP_W-1:0]           strapSync;
  init_state_t                  initState;
  logic [15:0]                  gain;
  logic [NUM_OUTPUTS-1:0][15:0] shareCfg;
  logic                         running;
  logic                         mapped;
  logic                         accepted;
  logic                         wrGain;
  logic                         wrShare;
  logic                         railShared;
  logic signed [4:0]            splitExp;
  logic signed [10:0]           splitMant;
  logic [15:0]                  next_rdata;

  // Command codes that this block answers.
  function automatic logic isMapped(input logic [7:0] code);
    isMapped = (code == CMD_GAIN) || (code == CMD_SHARE);
  endfunction : isMapped

  // Offset of a phase in 1/256 of a switching period, spread evenly over the rail.
  function automatic logic [7:0] spreadOffset(input logic [2:0] pos, input logic [2:0] cnt);
    logic [7:0]  step;
    logic [10:0] prod;
    case (cnt)
      3'h0:    step = 8'h00;
      3'h1:    step = 8'h80;
      3'h2:    step = 8'h55;
      3'h3:    step = 8'h40;
      3'h4:    step = 8'h33;
      3'h5:    step = 8'h2B;
      3'h6:    step = 8'h25;
      default: step = 8'h20;
    endcase
    prod = {3'h0, step} * {8'h00, pos};
    spreadOffset = prod[7:0];
  endfunction : spreadOffset

  // Reset is released through two flip-flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta    <= 1'b0;
      rstLocal_n <= 1'b0;
    end else begin
      rstMeta    <= 1'b1;
      rstLocal_n <= rstMeta;
    end
  end

  // The strap pins are asynchronous and pass two flip-flops before use.
  always_ff @(posedge sys_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      strapMeta <= '0;
      strapSync <= '0;
    end else begin
      strapMeta <= strapAddr;
      strapSync <= strapMeta;
    end
  end

  // The strap is caught only after the synchroniser has filled, so no pin feeds the reset.
  always_ff @(posedge sys_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      initState <= INIT_FILL0;
    end else begin
      case (initState)
        INIT_FILL0: initState <= INIT_FILL1;
        INIT_FILL1: initState <= INIT_LOAD;
        INIT_LOAD:  initState <= INIT_RUN;
        INIT_RUN:   initState <= INIT_RUN;
        default:    initState <= INIT_FILL0;
      endcase
    end
  end

  assign running  = (initState == INIT_RUN);
  assign mapped   = isMapped(cmdCode);
  // Protected writes are refused; reads stay open while protection is set.
  assign accepted = running && mapped && !(cmdWrite && writeProtect);
  assign wrGain   = cmdValid && cmdWrite && accepted && (cmdCode == CMD_GAIN);
  assign wrShare  = cmdValid && cmdWrite && accepted && (cmdCode == CMD_SHARE);

  // A single gain word, so the page select plays no part here.
  always_ff @(posedge sys_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      gain <= GAIN_RESET;
    end else if (wrGain) begin
      gain <= cmdWdata;
    end
  end

  // One sharing word per output, selected by the page.
  for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : gen_share
    always_ff @(posedge sys_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
        shareCfg[g] <= SHARE_RESET;
      end else if (initState == INIT_LOAD) begin
        shareCfg[g][RAIL_MSB:RAIL_LSB] <= strapSync[RAIL_W-1:0];
      end else if (wrShare && (cmdPage == 1'(g))) begin
        shareCfg[g] <= cmdWdata & SHARE_WMASK;
      end
    end

    // Automatic spreading overrides the phase_command_a command while the rail is shared.
    always_ff @(posedge sys_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
        phasePosition[g]  <= '0;
        railIdentifier[g] <= '0;
        phasesInRail[g]   <= '0;
        sharingActive[g]  <= 1'b0;
        phaseOffset[g]    <= '0;
      end else begin
        phasePosition[g]  <= shareCfg[g][POS_MSB:POS_LSB];
        railIdentifier[g] <= shareCfg[g][RAIL_MSB:RAIL_LSB];
        phasesInRail[g]   <= shareCfg[g][CNT_MSB:CNT_LSB];
        sharingActive[g]  <= railShared;
        if (railShared) begin
          phaseOffset[g] <= spreadOffset(shareCfg[g][POS_MSB:POS_LSB], TWO_PHASES);
        end else begin
          phaseOffset[g] <= phaseCommandA[g];
        end
      end
    end
  end

  // Only the two internal phases can form a rail; a larger phase count cannot be met here.
  assign railShared = (shareCfg[0][RAIL_MSB:RAIL_LSB] == shareCfg[1][RAIL_MSB:RAIL_LSB])
                   && (shareCfg[0][CNT_MSB:CNT_LSB] == TWO_PHASES)
                   && (shareCfg[1][CNT_MSB:CNT_LSB] == TWO_PHASES);

  linear11_split u_gain_split (
    .rawWord  (gain),
    .exponent (splitExp),
    .mantissa (splitMant),
    .negative ()
  );

  // The decoded gain feeds the input current calculation.
  always_ff @(posedge sys_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      gainExponent <= '0;
      gainMantissa <= '0;
    end else begin
      gainExponent <= splitExp;
      gainMantissa <= splitMant;
    end
  end

  always_comb begin
    next_rdata = '0;
    if (cmdCode == CMD_GAIN) begin
      next_rdata = gain;
    end else if (cmdCode == CMD_SHARE) begin
      next_rdata = shareCfg[cmdPage] & SHARE_WMASK;
    end
  end

  // Every command gets exactly one answer on the following edge.
  always_ff @(posedge sys_clk or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      cmdAck   <= 1'b0;
      cmdNack  <= 1'b0;
      cmdRdata <= '0;
    end else begin
      cmdAck  <= cmdValid && accepted;
      cmdNack <= cmdValid && !accepted;
      if (cmdValid && !cmdWrite && accepted) begin
        cmdRdata <= next_rdata;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstLocal_n);

  property p_gain_reset;
    (initState == INIT_FILL1) |-> (gain == GAIN_RESET);
  endproperty
  a_gain_reset: assert property (p_gain_reset)
    else $error("Gain does not hold its reset value before the first command.");

  property p_gain_write;
    (cmdValid && cmdWrite && running && !writeProtect && (cmdCode == CMD_GAIN))
      |=> (gain == $past(cmdWdata)) ##1 (gainMantissa == $signed($past(gain[MANT_MSB:MANT_LSB])));
  endproperty
  a_gain_write: assert property (p_gain_write)
    else $error("Gain write not stored or not passed to the decoded mantissa.");

  property p_protect;
    (cmdValid && cmdWrite && writeProtect && running)
      |=> cmdNack && !cmdAck && $stable(gain) && $stable(shareCfg);
  endproperty
  a_protect: assert property (p_protect)
    else $error("A protected write changed a register or was acknowledged.");

  property p_global_read;
    (cmdValid && !cmdWrite && running && (cmdCode == CMD_GAIN))
      |=> cmdAck && (cmdRdata == $past(gain));
  endproperty
  a_global_read: assert property (p_global_read)
    else $error("Gain read did not return the one shared gain word.");

  property p_unused_zero;
    running |-> (shareCfg[0][7:3] == 5'h00) && (shareCfg[1][7:3] == 5'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("Unused sharing configuration bits are not zero.");

  // The read path is watched apart from the storage, since the read mask could be lost on its own.
  property p_unused_read;
    (cmdValid && !cmdWrite && running && (cmdCode == CMD_SHARE))
      |=> cmdAck && (cmdRdata[7:3] == 5'h00);
  endproperty
  a_unused_read: assert property (p_unused_read)
    else $error("Unused sharing configuration bits do not read as zero.");

  property p_strap_load;
    (initState == INIT_LOAD)
      |=> (shareCfg[0] == {3'h0, $past(strapSync[RAIL_W-1:0]), 8'h00})
       && (shareCfg[1] == {3'h0, $past(strapSync[RAIL_W-1:0]), 8'h00});
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("Rail identifier not loaded from the strapped address.");

  property p_exponent;
    running |=> (gainExponent == $signed($past(gain[EXP_MSB:EXP_LSB])));
  endproperty
  a_exponent: assert property (p_exponent)
    else $error("Gain exponent is not the signed top five bits.");

  property p_spread;
    (railShared && (shareCfg[1][POS_MSB:POS_LSB] == 3'h1))
      |=> sharingActive[1] && (phaseOffset[1] == 8'h80);
  endproperty
  a_spread: assert property (p_spread)
    else $error("Second phase of a shared rail is not offset by half a period.");

  property p_phase_command_a;
    !railShared |=> !sharingActive[0] && (phaseOffset[0] == $past(phaseCommandA[0]));
  endproperty
  a_phase_command_a: assert property (p_phase_command_a)
    else $error("Unshared output does not follow its phase_command_a offset.");

  property p_own_phases;
    (shareCfg[0][CNT_MSB:CNT_LSB] != TWO_PHASES) |=> (sharingActive == 2'h0);
  endproperty
  a_own_phases: assert property (p_own_phases)
    else $error("Sharing reported for a rail wider than the two internal phases.");

  property p_fields;
    wrShare && !cmdPage |=> ##1 (phasePosition[0] == $past(cmdWdata[POS_MSB:POS_LSB], 2))
      && (railIdentifier[0] == $past(cmdWdata[RAIL_MSB:RAIL_LSB], 2))
      && (phasesInRail[0] == $past(cmdWdata[CNT_MSB:CNT_LSB], 2));
  endproperty
  a_fields: assert property (p_fields)
    else $error("Sharing configuration fields do not reach the outputs.");
endmodule : phase_rail_config_regs

// File: shared/phase_rail_pkg.sv
// Constants shared by the rail and phase configuration register block.
package phase_rail_pkg;
  localparam int          NUM_OUTPUTS   = 2;
  localparam int          STRAP_W       = 7;
  localparam int          RAIL_W        = 5;
  // Command codes of the two registers.
  localparam logic [7:0]  CMD_GAIN      = 8'hD2;
  localparam logic [7:0]  CMD_SHARE     = 8'hD3;
  // Reset values.
  localparam logic [15:0] GAIN_RESET    = 16'hC200;
  localparam logic [15:0] SHARE_RESET   = 16'h0000;
  // Linear-11 field positions.
  localparam int          EXP_MSB       = 15;
  localparam int          EXP_LSB       = 11;
  localparam int          MANT_MSB      = 10;
  localparam int          MANT_LSB      = 0;
  // Sharing configuration field positions.
  localparam int          POS_MSB       = 15;
  localparam int          POS_LSB       = 13;
  localparam int          RAIL_MSB      = 12;
  localparam int          RAIL_LSB      = 8;
  localparam int          CNT_MSB       = 2;
  localparam int          CNT_LSB       = 0;
  localparam logic [15:0] SHARE_WMASK   = 16'hFF07;
  // Phase count field value that means two phases.
  localparam logic [2:0]  TWO_PHASES    = 3'h1;
  typedef enum {INIT_FILL0, INIT_FILL1, INIT_LOAD, INIT_RUN} init_state_t;
endpackage : phase_rail_pkg

// File: hw/linear11_split.sv
// Splits a Linear-11 word into its signed exponent and signed mantissa.
module linear11_split (
  // Raw register word
  input  wire logic        [15:0] rawWord,
  // Decoded fields
  output logic signed      [4:0]  exponent,
  output logic signed      [10:0] mantissa,
  output logic                    negative
);
  import phase_rail_pkg::*;

  // Both fields are two's complement, so a plain reinterpretation is enough.
  assign exponent = $signed(rawWord[EXP_MSB:EXP_LSB]);
  assign mantissa = $signed(rawWord[MANT_MSB:MANT_LSB]);
  assign negative = rawWord[MANT_MSB];
endmodule : linear11_split

// File: tb/host_cmd_model.sv
// Host side model that issues one register command at a time on the command port.
module host_cmd_model (
  // Clock
  input  wire logic        sys_clk,
  // Command port
  output logic             cmdValid,
  output logic             cmdWrite,
  output logic [7:0]       cmdCode,
  output logic             cmdPage,
  output logic [15:0]      cmdWdata,
  input  wire logic        cmdAck,
  input  wire logic        cmdNack,
  input  wire logic [15:0] cmdRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode  = 8'h00;
    cmdPage  = 1'b0;
    cmdWdata = 16'h0000;
  end
  task automatic access(input logic wr, input logic [7:0] code, input logic pg, input logic [15:0] wd,
                        output logic ack, output logic nack, output logic [15:0] rd);
    @(negedge sys_clk);
    cmdValid = 1'b1;
    cmdWrite = wr;
    cmdCode  = code;
    cmdPage  = pg;
    cmdWdata = wd;
    @(negedge sys_clk);
    // The answer stands for one cycle only, so it is taken here before the command is released.
    ack  = cmdAck;
    nack = cmdNack;
    rd   = cmdRdata;
    cmdValid = 1'b0;
    // Qualifiers are inverted once released, so a design that samples them late cannot pass by luck.
    cmdWrite = ~cmdWrite;
    cmdCode  = ~cmdCode;
    cmdPage  = ~cmdPage;
    cmdWdata = ~cmdWdata;
  endtask : access
endmodule : host_cmd_model

// File: tb/phase_rail_config_regs_tb.sv
// Self-checking testbench of the rail and phase configuration registers.
module phase_rail_config_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import phase_rail_pkg::*;
  logic                               sys_clk;
  logic                               rst_n;
  logic [STRAP_W-1:0]                 strapAddr;
  logic                               cmdValid, cmdWrite, cmdPage, cmdAck, cmdNack, writeProtect;
  logic [7:0]                         cmdCode;
  logic [15:0]                        cmdWdata, cmdRdata;
  logic [NUM_OUTPUTS-1:0][7:0]        phaseCommandA, phaseOffset;
  logic signed [4:0]                  gainExponent;
  logic signed [10:0]                 gainMantissa;
  logic [NUM_OUTPUTS-1:0][2:0]        phasePosition, phasesInRail;
  logic [NUM_OUTPUTS-1:0][4:0]        railIdentifier;
  logic [NUM_OUTPUTS-1:0]             sharingActive;
  int                                 n_mismatch = 0;
  int                                 n_tests = 0;
  phase_rail_config_regs DUT (.sys_clk(sys_clk), .rst_n(rst_n), .strapAddr(strapAddr), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdPage(cmdPage), .cmdWdata(cmdWdata), .writeProtect(writeProtect),
    .cmdAck(cmdAck), .cmdNack(cmdNack), .cmdRdata(cmdRdata), .phaseCommandA(phaseCommandA),
    .gainExponent(gainExponent), .gainMantissa(gainMantissa), .phasePosition(phasePosition),
    .railIdentifier(railIdentifier), .phasesInRail(phasesInRail), .sharingActive(sharingActive),
    .phaseOffset(phaseOffset));
  host_cmd_model host (.sys_clk(sys_clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdPage(cmdPage), .cmdWdata(cmdWdata), .cmdAck(cmdAck), .cmdNack(cmdNack), .cmdRdata(cmdRdata));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      n_mismatch++;
    end
  endtask : check
  task automatic wr(input logic [7:0] code, input logic pg, input logic [15:0] wd, input logic okay);
    logic ack, nack;
    logic [15:0] rd;
    host.access(1'b1, code, pg, wd, ack, nack, rd);
    check("write answer", {14'h0000, okay, !okay}, {14'h0000, ack, nack});
  endtask : wr
  task automatic rd(input logic [7:0] code, input logic pg, input logic [15:0] exp, input logic okay);
    logic ack, nack;
    logic [15:0] data;
    host.access(1'b0, code, pg, 16'h0000, ack, nack, data);
    check("read answer", {14'h0000, okay, !okay}, {14'h0000, ack, nack});
    if (okay) check("cmdRdata", exp, data);
  endtask : rd
  task automatic settle();
    repeat (3) @(negedge sys_clk);
  endtask : settle
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    #4000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    strapAddr = 7'h55;
    writeProtect = 1'b0;
    phaseCommandA = 16'h0000;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    rd(CMD_GAIN, 1'b0, GAIN_RESET, 1'b1);
    check("gainExponent", 16'h0018, {11'h000, gainExponent});
    check("gainMantissa", 16'h0200, {5'h00, gainMantissa});
    rd(CMD_SHARE, 1'b0, 16'h1500, 1'b1);
    rd(CMD_SHARE, 1'b1, 16'h1500, 1'b1);
    check("railIdentifier1", 16'h0015, {11'h000, railIdentifier[1]});
    $display("test reset values done");
    wr(CMD_SHARE, 1'b0, 16'hBEFD, 1'b1);
    rd(CMD_SHARE, 1'b0, 16'hBE05, 1'b1);
    check("phasePosition0", 16'h0005, {13'h0000, phasePosition[0]});
    check("railIdentifier0", 16'h001E, {11'h000, railIdentifier[0]});
    check("phasesInRail0", 16'h0005, {13'h0000, phasesInRail[0]});
    rd(CMD_SHARE, 1'b1, 16'h1500, 1'b1);
    $display("test sharing fields done");
    wr(CMD_GAIN, 1'b1, 16'h17FF, 1'b1);
    rd(CMD_GAIN, 1'b0, 16'h17FF, 1'b1);
    check("gainExponent", 16'h0002, {11'h000, gainExponent});
    check("gainMantissa", 16'h07FF, {5'h00, gainMantissa});
    writeProtect = 1'b1;
    wr(CMD_SHARE, 1'b0, 16'h0000, 1'b0);
    wr(CMD_GAIN, 1'b0, 16'h0000, 1'b0);
    rd(CMD_GAIN, 1'b1, 16'h17FF, 1'b1);
    rd(CMD_SHARE, 1'b0, 16'hBE05, 1'b1);
    writeProtect = 1'b0;
    rd(8'hD4, 1'b0, 16'h0000, 1'b0);
    $display("test gain and protection done");
    phaseCommandA = 16'h2211;
    wr(CMD_SHARE, 1'b0, 16'h0301, 1'b1);
    wr(CMD_SHARE, 1'b1, 16'h0301, 1'b1);
    wr(CMD_SHARE, 1'b1, 16'h2301, 1'b1);
    settle();
    check("sharingActive", 16'h0003, {14'h0000, sharingActive});
    check("phaseOffset", 16'h8000, phaseOffset);
    check("phasePosition1", 16'h0001, {13'h0000, phasePosition[1]});
    check("phasesInRail1", 16'h0001, {13'h0000, phasesInRail[1]});
    wr(CMD_SHARE, 1'b1, 16'h2302, 1'b1);
    settle();
    check("sharingActive", 16'h0000, {14'h0000, sharingActive});
    check("phaseOffset", 16'h2211, phaseOffset);
    wr(CMD_SHARE, 1'b1, 16'h2401, 1'b1);
    settle();
    check("sharingActive", 16'h0000, {14'h0000, sharingActive});
    check("phaseOffset", 16'h2211, phaseOffset);
    $display("test phase spreading done");
    wrap_up();
  end
endmodule : phase_rail_config_regs_tb
